// File: core/cst_map.vh
// Register map, field positions and reset values of the capacitive sense control.
// Assumes an APB slave with 32-bit data, one register per aligned word.
// Contract
// [R01] Sixteen sense inputs, exactly one connected; code connects none while enable bit 7 is clear
// [R02] Software writes channel, sets pin analog
// [R03] Enabled module drives oscillator onto channel
// [R04] Read-only flag shows sourcing or sinking
// [R05] Two-bit field picks three current ranges
// [R06] Oscillator clocks 8-bit or 16-bit timer
// [R07] Select set, source clear: timer0 counts
// [R08] Timer1 source field 11 counts oscillator
// [R09] Timer1 off, free, or gated counting
// [R10] Time base never from oscillator-clocked timer
// [R11] Prefer overflow flags via gate toggle mode
// [R12] Clear timer at start, save at end
// [R13] Threshold midway between loaded, unloaded counts
// [R14] Enable bit 7 runs or shuts module
// [R15] Oscillator runs in sleep while enabled
// [R16] Oscillator synchronised; one count per cycle
`ifndef CST_MAP_VH
`define CST_MAP_VH

// Byte offsets
`define CST_ADDR_SENSE_CONTROL  8'h00
`define CST_ADDR_SENSE_CHANNEL  8'h04
`define CST_ADDR_TIMER0_CONTROL 8'h08
`define CST_ADDR_TIMER1_CONTROL 8'h0C
`define CST_ADDR_TIMER1_GATE    8'h10
`define CST_ADDR_TIMER0_COUNT   8'h14
`define CST_ADDR_TIMER1_COUNT   8'h18

// sense_control_reg fields
`define CST_BIT_ENABLE          7
`define CST_RANGE_HI            3
`define CST_RANGE_LO            2
`define CST_BIT_PHASE           1
`define CST_BIT_T0_SENSE_SEL    0
// sense_channel_reg field
`define CST_CHAN_HI             3
// timer0 control field
`define CST_BIT_T0_SOURCE       5
// timer1_control_reg fields
`define CST_T1CS_HI             7
`define CST_T1CS_LO             6
`define CST_BIT_T1_ON           0
// timer1 gate fields
`define CST_BIT_GATE_EN         7
`define CST_BIT_GATE_TOGGLE     5

// Encodings and reset values
`define CST_T1CS_SENSE          2'h3
`define CST_T0_SOURCE_RESET     1'h1
`define CST_RANGE_OFF           2'h0
`define CST_WORD_ZERO           32'h0000_0000

`endif

// File: core/cst_top.v
// Capacitive sense control: channel mux select, current range, phase flag,
// and the 8-bit and 16-bit counters clocked by the sense oscillator.
// Assumes the analog oscillator output arrives asynchronously on osc_in and
// the gate source pulse comes from logic on clock_in.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`include "cst_map.vh"

module cst_top #(
  parameter CHANNELS = 16,
  parameter CHAN_W   = 4
) (
  // Clock, reset, enable
  input  wire                clock_in,
  input  wire                resetn_in,
  input  wire                ce_in,
  // APB slave
  input  wire                psel_in,
  input  wire                penable_in,
  input  wire                pwrite_in,
  input  wire [7:0]          paddr_in,
  input  wire [31:0]         pwdata_in,
  output reg  [31:0]         prdata_out,
  output reg                 pready_out,
  output reg                 pslverr_out,
  // Oscillator and gate
  input  wire                osc_in,
  input  wire                gate_pulse_in,
  // Analog controls
  output reg                 osc_enable_out,
  output reg  [1:0]          current_range_out,
  output reg  [CHAN_W-1:0]   sense_channel_out,
  output reg  [CHANNELS-1:0] sense_pin_connect_out,
  // Timer events
  output reg                 timer0_overflow_out,
  output reg                 timer1_overflow_out
);

  ////////////////////////////////////////////////////////////////////////
  function [2:0] reg_index;
    input [7:0] addr;
    begin
      case (addr)
        `CST_ADDR_SENSE_CONTROL:  reg_index = 3'h0;
        `CST_ADDR_SENSE_CHANNEL:  reg_index = 3'h1;
        `CST_ADDR_TIMER0_CONTROL: reg_index = 3'h2;
        `CST_ADDR_TIMER1_CONTROL: reg_index = 3'h3;
        `CST_ADDR_TIMER1_GATE:    reg_index = 3'h4;
        `CST_ADDR_TIMER0_COUNT:   reg_index = 3'h5;
        `CST_ADDR_TIMER1_COUNT:   reg_index = 3'h6;
        default:                  reg_index = 3'h7;
      endcase
    end
  endfunction

  reg              sense_module_enable;
  reg [1:0]        current_range_select;
  reg              timer0_sense_clock_select;
  reg [CHAN_W-1:0] sense_channel_select;
  reg              timer0_clock_source;
  reg [1:0]        timer1_clock_source;
  reg              timer1_on;
  reg              timer1_gate_enable;
  reg              gate_toggle_mode;
  reg [7:0]        timer0_count;
  reg [15:0]       timer1_count;
  reg              osc_meta;
  reg              osc_sync;
  reg              osc_last;
  reg              gate_state;

  wire       apb_access = psel_in & penable_in & pready_out;
  wire       apb_write  = apb_access & pwrite_in;
  wire [2:0] wr_index   = reg_index(paddr_in);
  // Phase flag only meaningful while oscillator runs
  wire       osc_phase_flag = osc_sync & sense_module_enable; // [R04]
  // One tick per oscillator period, on its rising edge
  wire       osc_tick = osc_sync & ~osc_last & sense_module_enable; // [R16]
  wire       t0_sense = timer0_sense_clock_select & ~timer0_clock_source; // [R07]
  wire       t1_sense = (timer1_clock_source == `CST_T1CS_SENSE); // [R08]
  // Level gate or toggled gate built from overflow pulses
  wire       gate_open = gate_toggle_mode ? gate_state : gate_pulse_in; // [R11]
  wire       t1_run = timer1_on & (~timer1_gate_enable | gate_open); // [R09]
  wire       t0_inc = t0_sense & osc_tick; // [R06]
  wire       t1_inc = t1_sense & osc_tick & t1_run; // [R06]

  ////////////////////////////////////////////////////////////////////////
  // Oscillator synchroniser; first stage read only by the second
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_last <= 1'b0;
    end else if (ce_in) begin
      osc_meta <= osc_in; // [R16]
      osc_sync <= osc_meta;
      osc_last <= osc_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB: one wait state so read data and pready both leave flip-flops
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= `CST_WORD_ZERO;
    end else if (ce_in) begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & (wr_index == 3'h7);
      prdata_out  <= `CST_WORD_ZERO;
      if (psel_in & penable_in & ~pready_out & ~pwrite_in) begin
        case (wr_index)
          3'h0: begin
            prdata_out[`CST_BIT_ENABLE]                  <= sense_module_enable;
            prdata_out[`CST_RANGE_HI:`CST_RANGE_LO]      <= current_range_select;
            prdata_out[`CST_BIT_PHASE]                   <= osc_phase_flag; // [R04]
            prdata_out[`CST_BIT_T0_SENSE_SEL]            <= timer0_sense_clock_select;
          end
          3'h1: prdata_out[CHAN_W-1:0]                   <= sense_channel_select;
          3'h2: prdata_out[`CST_BIT_T0_SOURCE]           <= timer0_clock_source;
          3'h3: begin
            prdata_out[`CST_T1CS_HI:`CST_T1CS_LO]        <= timer1_clock_source;
            prdata_out[`CST_BIT_T1_ON]                   <= timer1_on;
          end
          3'h4: begin
            prdata_out[`CST_BIT_GATE_EN]                 <= timer1_gate_enable;
            prdata_out[`CST_BIT_GATE_TOGGLE]             <= gate_toggle_mode;
          end
          3'h5: prdata_out[7:0]                          <= timer0_count;
          3'h6: prdata_out[15:0]                         <= timer1_count;
          default: prdata_out <= `CST_WORD_ZERO;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      sense_module_enable       <= 1'b0;
      current_range_select      <= `CST_RANGE_OFF;
      timer0_sense_clock_select <= 1'b0;
      sense_channel_select      <= {CHAN_W{1'b0}};
      timer0_clock_source       <= `CST_T0_SOURCE_RESET;
      timer1_clock_source       <= 2'h0;
      timer1_on                 <= 1'b0;
      timer1_gate_enable        <= 1'b0;
      gate_toggle_mode          <= 1'b0;
    end else if (ce_in && apb_write) begin
      case (wr_index)
        3'h0: begin
          sense_module_enable       <= pwdata_in[`CST_BIT_ENABLE]; // [R14]
          current_range_select      <= pwdata_in[`CST_RANGE_HI:`CST_RANGE_LO]; // [R05]
          timer0_sense_clock_select <= pwdata_in[`CST_BIT_T0_SENSE_SEL];
        end
        3'h1: sense_channel_select  <= pwdata_in[CHAN_W-1:0]; // [R02]
        3'h2: timer0_clock_source   <= pwdata_in[`CST_BIT_T0_SOURCE];
        3'h3: begin
          timer1_clock_source       <= pwdata_in[`CST_T1CS_HI:`CST_T1CS_LO];
          timer1_on                 <= pwdata_in[`CST_BIT_T1_ON];
        end
        3'h4: begin
          timer1_gate_enable        <= pwdata_in[`CST_BIT_GATE_EN];
          gate_toggle_mode          <= pwdata_in[`CST_BIT_GATE_TOGGLE];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counters; a software write (clear or preset) wins over a tick
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      timer0_count        <= 8'h00;
      timer1_count        <= 16'h0000;
      timer0_overflow_out <= 1'b0;
      timer1_overflow_out <= 1'b0;
      gate_state          <= 1'b0;
    end else if (ce_in) begin
      timer0_overflow_out <= 1'b0;
      timer1_overflow_out <= 1'b0;
      // Toggle flips on every clock with gate_pulse_in high; cleared outside toggle mode
      if (!gate_toggle_mode)
        gate_state <= 1'b0;
      else if (gate_pulse_in)
        gate_state <= ~gate_state; // [R11]
      if (apb_write && wr_index == 3'h5) begin
        timer0_count <= pwdata_in[7:0]; // [R12]
      end else if (t0_inc) begin
        timer0_count        <= timer0_count + 8'h01; // [R07]
        timer0_overflow_out <= (timer0_count == 8'hFF);
      end
      if (apb_write && wr_index == 3'h6) begin
        timer1_count <= pwdata_in[15:0]; // [R12]
      end else if (t1_inc) begin
        timer1_count        <= timer1_count + 16'h0001; // [R08]
        timer1_overflow_out <= (timer1_count == 16'hFFFF);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog controls; no sleep input, so the oscillator follows enable only
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_pin
      always @(posedge clock_in) begin
        if (!resetn_in)
          sense_pin_connect_out[g] <= 1'b0;
        else if (ce_in)
          sense_pin_connect_out[g] <= sense_module_enable &
                                      (sense_channel_select == g); // [R01] [R03]
      end
    end
  endgenerate

  always @(posedge clock_in) begin
    if (!resetn_in) begin
      osc_enable_out    <= 1'b0;
      current_range_out <= `CST_RANGE_OFF;
      sense_channel_out <= {CHAN_W{1'b0}};
    end else if (ce_in) begin
      osc_enable_out    <= sense_module_enable; // [R14] [R15]
      current_range_out <= sense_module_enable ? current_range_select : `CST_RANGE_OFF; // [R05]
      sense_channel_out <= sense_channel_select; // [R03]
    end
  end

endmodule

// File: tb/cst_checker.sv
// Port assertions for the capacitive sense control, bound to cst_top.
// Assumes one APB wait state; checks pause while ce_in freezes the block.
module cst_checker #(
  parameter CHANNELS = 16,
  parameter CHAN_W   = 4
) (
  // Clock and reset
  input wire logic                clock_in,
  input wire logic                resetn_in,
  input wire logic                ce_in,
  // APB
  input wire logic                psel_in,
  input wire logic                penable_in,
  input wire logic                pwrite_in,
  input wire logic [7:0]          paddr_in,
  input wire logic [31:0]         pwdata_in,
  input wire logic [31:0]         prdata_out,
  input wire logic                pready_out,
  input wire logic                pslverr_out,
  // Sense side
  input wire logic                osc_in,
  input wire logic                osc_enable_out,
  input wire logic [1:0]          current_range_out,
  input wire logic [CHAN_W-1:0]   sense_channel_out,
  input wire logic [CHANNELS-1:0] sense_pin_connect_out,
  input wire logic                timer0_overflow_out,
  input wire logic                timer1_overflow_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in || !ce_in);
  wire done = psel_in && penable_in && pready_out;
  ////////////////////////////////////////
  chk_mux_onehot: assert property (osc_enable_out |->
    sense_pin_connect_out == (CHANNELS'(1) << sense_channel_out)) else $error("pin select");
  chk_off_quiet: assert property (!osc_enable_out |->
    sense_pin_connect_out == '0 && current_range_out == 2'h0) else $error("not shut off");
  // Register file then output flop: the pins follow two edges after the write
  chk_enable_write: assert property (done && pwrite_in && paddr_in == 8'h00 |-> ##2
    osc_enable_out == $past(pwdata_in[7], 2)) else $error("enable not taken");
  chk_range_write: assert property (done && pwrite_in && paddr_in == 8'h00 && pwdata_in[7]
    |-> ##2 current_range_out == $past(pwdata_in[3:2], 2)) else $error("range not taken");
  chk_chan_write: assert property (done && pwrite_in && paddr_in == 8'h04 |-> ##2
    sense_channel_out == $past(pwdata_in[CHAN_W-1:0], 2)) else $error("channel not taken");
  chk_ready_wait: assert property (psel_in && penable_in && !pready_out |=>
    pready_out ##1 !pready_out) else $error("ready timing");
  chk_unmapped_err: assert property (done && paddr_in > 8'h18 |->
    pslverr_out && prdata_out == 32'h0) else $error("unmapped access");
  chk_phase_read: assert property (done && !pwrite_in && paddr_in == 8'h00 |->
    prdata_out[6:4] == 3'h0 && (osc_enable_out || !prdata_out[1])) else $error("phase bit");
  chk_tick_cause: assert property (timer0_overflow_out || timer1_overflow_out |->
    $past(osc_in, 3) || $past(osc_in, 4) || $past(osc_in, 5)) else $error("tick w/o osc");
  cov_t0_wrap: cover property (timer0_overflow_out);
  cov_t1_wrap: cover property (timer1_overflow_out);
  cov_err: cover property (done && pslverr_out);
endmodule

// File: tb/cst_pad_model.sv
// Touch pad with its sense oscillator, seen as the comparator output.
// Assumes half_in is at least 3 so each level lasts three clocks or more.
module cst_pad_model (
  // Clock
  input  wire logic       clock_in,
  // Run request and pad load
  input  wire logic       run_in,
  input  wire logic [3:0] half_in,
  // Comparator output, high while sourcing
  output logic            osc_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  // Pin sits analog with its driver off; no current when the module is off
  always @(posedge clock_in) begin
    if (!run_in) begin
      osc_out <= 1'b0;
      cnt     <= 4'h0;
    end else if (cnt == half_in - 4'h1) begin
      osc_out <= !osc_out;
      cnt     <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// File: tb/cst_top_tb.sv
// Self-checking bench for cst_top with an APB master and a pad model.
// Assumes the one-wait-state APB answer and two-flop oscillator sync.
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cst_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        pad_run = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic        gate_pulse_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0]  half_sel = 4'h4;
  logic [31:0] prdata_out, rdata;
  logic        pready_out, pslverr_out, osc_in, osc_enable_out, perr;
  logic        timer0_overflow_out, timer1_overflow_out;
  logic [1:0]  current_range_out;
  logic [3:0]  sense_channel_out;
  logic [15:0] sense_pin_connect_out;
  int          error_cnt = 0, tests_run = 0, rises = 0, ovf0 = 0, ovf1 = 0;
  cst_top uut (.clock_in, .resetn_in, .ce_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .osc_in, .gate_pulse_in,
    .osc_enable_out, .current_range_out, .sense_channel_out, .sense_pin_connect_out,
    .timer0_overflow_out, .timer1_overflow_out);
  // Bench can hold the pad still so that no edge is in flight at a window's end
  cst_pad_model pad (.clock_in, .run_in(osc_enable_out & pad_run), .half_in(half_sel),
    .osc_out(osc_in));
  always @(posedge osc_in) rises++;
  always @(posedge clock_in) ovf0 += int'(timer0_overflow_out);
  always @(posedge clock_in) ovf1 += int'(timer1_overflow_out);
  initial forever #5 clock_in = !clock_in;
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock_in);
    psel_in   <= 1'b1;
    pwrite_in <= wr;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      close_out();
    end else begin
      rdata = prdata_out;
      perr  = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask
  task automatic pulse_gate();
    @(posedge clock_in);
    gate_pulse_in <= 1'b1;
    @(posedge clock_in);
    gate_pulse_in <= 1'b0;
  endtask
  // Preset, let the pad run a fixed window, stop it, then read back the count
  task automatic measure(input logic [7:0] ca, input logic [31:0] ctrl, start,
                         output logic [31:0] got, output int n);
    int r;
    apb(1'b1, ca, start);
    apb(1'b1, 8'h00, ctrl);
    r = rises;
    pad_run <= 1'b1;
    repeat (240) @(posedge clock_in);
    pad_run <= 1'b0;
    // Sync and edge detect take three clocks before the last rise lands
    repeat (6) @(posedge clock_in);
    n = rises - r;
    apb(1'b1, 8'h00, ctrl & 32'h7F);
    apb(1'b0, ca, 32'h0);
    got = rdata;
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rdata, 32'h20)
    apb(1'b1, 8'h00, 32'h02);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rdata, 32'h0)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({perr, rdata}, 33'h1_0000_0000)
    // Clock enable low must hold the enable output where it stood
    apb(1'b1, 8'h00, 32'h80);
    ce_in <= 1'b0;
    repeat (3) @(negedge clock_in);
    `CHK(osc_enable_out, 1'b0)
    @(posedge clock_in);
    ce_in <= 1'b1;
    repeat (2) @(negedge clock_in);
    `CHK(osc_enable_out, 1'b1)
    $display("regs done");
  endtask
  task automatic t_mux();
    for (int ch = 0; ch < 16; ch++) begin
      apb(1'b1, 8'h04, ch);
      apb(1'b1, 8'h00, 32'h80 | ((ch % 3 + 1) << 2));
      repeat (2) @(negedge clock_in);
      `CHK(sense_pin_connect_out, 16'h1 << ch)
      `CHK(current_range_out, 2'(ch % 3 + 1))
    end
    apb(1'b1, 8'h00, 32'h0C);
    repeat (2) @(negedge clock_in);
    `CHK({current_range_out, sense_pin_connect_out}, 18'h0)
    $display("mux done");
  endtask
  task automatic t_timer0();
    logic [31:0] got;
    int n, o;
    apb(1'b1, 8'h08, 32'h0);
    o = ovf0;
    measure(8'h14, 32'h81, 32'hF0, got, n);
    `CHK(got, 32'(8'(8'hF0 + n)))
    `CHK(ovf0 - o, 1)
    measure(8'h14, 32'h80, 32'h05, got, n);
    `CHK(got, 32'h05)
    $display("timer0 done");
  endtask
  task automatic t_timer1();
    logic [7:0]  t1c [5] = '{8'hC1, 8'hC0, 8'hC1, 8'hC1, 8'h41};
    logic [7:0]  gc [5] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h00};
    logic        gl [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic        on [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [15:0] cnt [5];
    logic [31:0] got;
    int n, o;
    for (int i = 0; i < 5; i++) begin
      gate_pulse_in <= gl[i];
      half_sel      <= 4'(4 + i);
      apb(1'b1, 8'h0C, 32'(t1c[i]));
      apb(1'b1, 8'h10, 32'(gc[i]));
      o = ovf1;
      measure(8'h18, 32'h80, 32'hFFF0, got, n);
      cnt[i] = got[15:0] - 16'hFFF0;
      `CHK(got, on[i] ? 32'(16'(16'hFFF0 + n)) : 32'hFFF0)
      `CHK(ovf1 - o, int'(on[i] && n >= 16))
    end
    // Light pad (case 0) against heavier pad (case 3): midpoint splits them
    `CHK(cnt[3] < (cnt[0] + cnt[3]) / 2 && (cnt[0] + cnt[3]) / 2 < cnt[0], 1'b1)
    $display("timer1 done");
  endtask
  // Overflow-style pulses open and close the gate in toggle mode
  task automatic t_toggle();
    logic [31:0] got;
    int n;
    apb(1'b1, 8'h0C, 32'hC1);
    apb(1'b1, 8'h10, 32'hA0);
    measure(8'h18, 32'h80, 32'h10, got, n);
    `CHK(got, 32'h10)
    pulse_gate();
    measure(8'h18, 32'h80, 32'h10, got, n);
    `CHK(got, 32'(16'(16'h0010 + n)))
    pulse_gate();
    measure(8'h18, 32'h80, 32'h10, got, n);
    `CHK(got, 32'h10)
    $display("toggle done");
  endtask
  initial begin
    repeat (20) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_regs();
    t_mux();
    t_timer0();
    t_timer1();
    t_toggle();
    close_out();
  end
endmodule
bind cst_top cst_checker #(.CHANNELS(CHANNELS), .CHAN_W(CHAN_W)) chk (.clock_in, .resetn_in, .ce_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
  .pslverr_out, .osc_in, .osc_enable_out, .current_range_out, .sense_channel_out,
  .sense_pin_connect_out, .timer0_overflow_out, .timer1_overflow_out);
